//--- rtl/msa_pkg.sv
package msa_pkg;
   // Clock rates
   localparam longint CLK_HZ = 50000000;
   localparam longint MOD_HZ = 1048576;
   localparam longint CONV_HZ = 4000000;
   // Phase increments of the 32-bit rate accumulators
   localparam logic [31:0] MOD_INC = 32'((MOD_HZ << 32) / CLK_HZ);
   localparam logic [31:0] CONV_INC = 32'((CONV_HZ << 32) / CLK_HZ);
   // Oversampling ratio
   localparam int OVERSAMPLING_RATIO = 256;
   localparam logic [7:0] OSR_LAST = 8'(OVERSAMPLING_RATIO - 1);
   // Autoscan
   localparam int SCAN_CHANNELS = 16;
   localparam logic [3:0] CH_LAST = 4'(SCAN_CHANNELS - 1);
   localparam logic [3:0] SAMPLE_LAST = 4'h7;
   localparam logic [3:0] CONVERT_LAST = 4'hb;
   localparam logic [3:0] PH1_V_CH = 4'h5;
   localparam logic [3:0] PH2_V_CH = 4'h4;
   localparam logic [3:0] PH3_V_CH = 4'h3;
   localparam logic [3:0] TEMP_CH = 4'ha;
   localparam logic [3:0] SYS_SUPPLY_CH = 4'hb;
   localparam logic [3:0] AUX_SUPPLY_CH = 4'hc;
   // Result formatting
   localparam logic [9:0] SAR_MID = 10'h200;
   // Frame closing
   localparam logic [15:0] FRAME_MAX = 16'h2000;
   // Register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CYCLES = 8'h08;
   localparam logic [7:0] REG_SHIFT = 8'h0c;
   localparam logic [7:0] REG_COUNT = 8'h10;
   localparam logic [7:0] REG_MON0 = 8'h14;
   localparam logic [7:0] REG_MON1 = 8'h18;
   localparam logic [7:0] REG_HOLD_BASE = 8'h80;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_SIGNED = 1;
   localparam int ST_READY = 0;
   localparam int ST_OVERRUN = 1;
   localparam logic RUN_RESET = 1'b1;
   localparam logic SIGNED_RESET = 1'b1;
   localparam logic [7:0] CYCLES_RESET = 8'h32;
   localparam logic [4:0] SHIFT_RESET = 5'h14;
   typedef enum logic [2:0] {
      SC_IDLE = 3'b001,
      SC_SAMPLE = 3'b010,
      SC_CONVERT = 3'b100
   } msa_scan_state_type;
endpackage : msa_pkg

//--- rtl/msa_rate_gen.sv
`timescale 1ns/1ps
`default_nettype none
// Phase accumulator: fractional division of the system clock
module msa_rate_gen
   import msa_pkg::*;
#(
   parameter logic [31:0] INC = MOD_INC
) (
   input wire logic clk,
   input wire logic srst,
   output logic tick,
   output logic phase_msb
);
   typedef struct packed {
      logic [31:0] acc;
      logic tick;
   } msa_rate_type;
   msa_rate_type s_q, s_d;
   logic [32:0] sum;

   always_comb begin
      sum = {1'b0, s_q.acc} + {1'b0, INC};
      s_d.acc = sum[31:0];
      s_d.tick = sum[32];
      if (srst) begin
         s_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   // Msb of the accumulator is a clock of the target rate, jitter one cycle
   assign tick = s_q.tick;
   assign phase_msb = s_q.acc[31];
endmodule : msa_rate_gen
`default_nettype wire

//--- rtl/msa_scan.sv
`timescale 1ns/1ps
`default_nettype none
module msa_scan
   import msa_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic conv_tick,
   input wire logic start,
   output logic [3:0] channel,
   output logic sampling,
   output logic converting,
   output logic done,
   output logic [3:0] done_ch
);
   typedef struct packed {
      msa_scan_state_type st;
      logic [3:0] ch;
      logic [3:0] cnt;
      logic done;
      logic [3:0] done_ch;
   } msa_scan_reg_type;
   msa_scan_reg_type s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      unique case (s_q.st)
         SC_IDLE: begin
            // A trigger during a scan is ignored; a scan ends long before the next one
            if (start) begin
               s_d.st = SC_SAMPLE;
               s_d.ch = '0;
               s_d.cnt = '0;
            end
         end
         SC_SAMPLE: begin
            if (conv_tick) begin
               if (s_q.cnt == SAMPLE_LAST) begin // R8
                  s_d.st = SC_CONVERT;
                  s_d.cnt = '0;
               end else begin
                  s_d.cnt = s_q.cnt + 4'h1;
               end
            end
         end
         SC_CONVERT: begin
            if (conv_tick) begin
               if (s_q.cnt == CONVERT_LAST) begin // R8
                  s_d.done = 1'b1;
                  s_d.done_ch = s_q.ch;
                  s_d.cnt = '0;
                  if (s_q.ch == CH_LAST) begin // R6
                     s_d.st = SC_IDLE;
                  end else begin
                     s_d.ch = s_q.ch + 4'h1;
                     s_d.st = SC_SAMPLE;
                  end
               end else begin
                  s_d.cnt = s_q.cnt + 4'h1;
               end
            end
         end
         default: begin
            s_d.st = SC_IDLE;
         end
      endcase
      if (srst) begin
         s_d = '0;
         s_d.st = SC_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign channel = s_q.ch;
   assign sampling = s_q.st[1];
   assign converting = s_q.st[2];
   assign done = s_q.done;
   assign done_ch = s_q.done_ch;
endmodule : msa_scan
`default_nettype wire

//--- rtl/msa_acquisition.sv
// Notes on behaviour
// [R1] Modulator clock 1.048576 MHz derived from the system clock.
// [R2] Sample rate is modulator rate divided by oversampling ratio 256.
// [R3] Current samples and voltage triggers both at 4096 Hz, in step.
// [R4] One sample notification pulse at every sampling instant.
// [R5] Three current channels, phases one to three.
// [R6] Each trigger starts an autoscan converting all 16 channels once.
// [R7] Voltage converter clocked at 4 MHz during autoscan.
// [R8] Per channel 8 sampling and 12 converting converter clocks.
// [R9] 10-bit results shown as 16-bit two's complement when signed format set.
// [R10] Codes span zero to the 2.0 V internal reference.
// [R11] Channels 12, 11, 10 supplies and temperature; 5, 4, 3 phase voltages.
// [R12] Frame-ready flag raised when a complete frame is available.
// [R13] Frame spans 50 or 60 mains cycles, locked to voltage crossings.
// [R14] Sample counter records samples accumulated per frame.
// [R15] Voltage squared sums held in 48-bit accumulators.
// [R16] Current squared, active and reactive sums in 64-bit accumulators.
// [R17] Each trigger processes the previously captured samples.
// [R18] Every sample of the frame goes into the accumulations.
// [R19] At frame end copy to holding set, then clear accumulators.
// [R20] Processor clears ready; holding set untouched while ready stands.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module msa_acquisition
   import msa_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic [23:0] PHASE_ONE_CURRENT_INPUT,
   input wire logic [23:0] PHASE_TWO_CURRENT_INPUT,
   input wire logic [23:0] PHASE_THREE_CURRENT_INPUT,
   output logic MOD_CLK,
   output logic SAMPLE_IRQ,
   output logic SAR_CLK,
   output logic [3:0] SAR_CHANNEL,
   output logic SAR_SAMPLE,
   output logic SAR_CONVERT,
   input wire logic [9:0] SAR_RESULT,
   output logic FRAME_READY
);
   typedef struct packed {
      logic [7:0] oversampling_ratio;
      logic irq;
      logic [2:0][15:0] vcap;
      logic [2:0][23:0] icap;
      logic [15:0] temp;
      logic [15:0] sys;
      logic [15:0] aux;
      logic [2:0][31:0][15:0] dly;
      logic [4:0] wp;
      logic pos;
      logic [7:0] cyc;
      logic [15:0] cnt;
      logic [2:0][47:0] acc_v;
      logic [2:0][63:0] acc_i;
      logic [2:0][63:0] acc_p;
      logic [2:0][63:0] acc_q;
      logic [2:0][47:0] hold_v;
      logic [2:0][63:0] hold_i;
      logic [2:0][63:0] hold_p;
      logic [2:0][63:0] hold_q;
      logic [15:0] hold_cnt;
      logic ready;
      logic overrun;
      logic run;
      logic sgn;
      logic [7:0] cycles_cfg;
      logic [4:0] shift;
      logic [31:0] rdata;
   } msa_state_type;
   msa_state_type s_q, s_d;

   logic mod_tick;
   logic conv_tick;
   logic sample_tick;
   logic scan_done;
   logic [3:0] scan_ch;

   function automatic logic [63:0] smul(input logic [23:0] a, input logic [23:0] b);
      logic signed [47:0] p;
      p = $signed(a) * $signed(b);
      return {{16{p[47]}}, p};
   endfunction : smul

   function automatic logic [23:0] vext(input logic [15:0] v);
      return {{8{v[15]}}, v};
   endfunction : vext

   // Signed form recentres the code on mid-reference before scaling
   function automatic logic [15:0] fmt(input logic [9:0] code, input logic sgn);
      return sgn ? {code ^ SAR_MID, 6'h00} : {6'h00, code};
   endfunction : fmt

   function automatic logic is_pos(input logic [15:0] v, input logic sgn);
      return sgn ? !v[15] : (v[9:0] >= SAR_MID);
   endfunction : is_pos

   msa_rate_gen #(
      .INC(MOD_INC)
   ) u_mod_rate (
      .clk(MCLK),
      .srst(SRST),
      .tick(mod_tick),
      .phase_msb(MOD_CLK)
   ); // R1

   msa_rate_gen #(
      .INC(CONV_INC)
   ) u_conv_rate (
      .clk(MCLK),
      .srst(SRST),
      .tick(conv_tick),
      .phase_msb(SAR_CLK)
   ); // R7

   msa_scan u_scan (
      .clk(MCLK),
      .srst(SRST),
      .conv_tick(conv_tick),
      .start(sample_tick),
      .channel(SAR_CHANNEL),
      .sampling(SAR_SAMPLE),
      .converting(SAR_CONVERT),
      .done(scan_done),
      .done_ch(scan_ch)
   ); // R6

   // One tick drives current capture and voltage scan start
   assign sample_tick = mod_tick && (s_q.oversampling_ratio == OSR_LAST) && s_q.run; // R2 R3

   always_comb begin
      logic [2:0][47:0] nv;
      logic [2:0][63:0] ni;
      logic [2:0][63:0] np;
      logic [2:0][63:0] nq;
      logic [15:0] v90;
      logic now_pos;
      logic rise;
      logic [7:0] cyc_n;
      logic [15:0] cnt_n;
      logic close;
      logic [4:0] idx;
      logic [63:0] w64;
      logic [63:0] vprod;
      nv = '0;
      ni = '0;
      np = '0;
      nq = '0;
      v90 = '0;
      now_pos = 1'b0;
      rise = 1'b0;
      cyc_n = '0;
      cnt_n = '0;
      close = 1'b0;
      idx = '0;
      w64 = '0;
      vprod = '0;
      s_d = s_q;
      s_d.irq = 1'b0;
      s_d.rdata = '0;

      if (mod_tick) begin
         s_d.oversampling_ratio = s_q.oversampling_ratio + 8'h01;
      end

      // Clears come first so that a set in the same cycle wins
      if (WR) begin
         unique case (ADDR)
            REG_CTRL: begin
               s_d.run = WDATA[CTRL_RUN];
               s_d.sgn = WDATA[CTRL_SIGNED];
            end
            REG_STATUS: begin
               if (WDATA[ST_READY]) begin
                  s_d.ready = 1'b0; // R20
               end
               if (WDATA[ST_OVERRUN]) begin
                  s_d.overrun = 1'b0;
               end
            end
            REG_CYCLES: s_d.cycles_cfg = WDATA[7:0];
            REG_SHIFT: s_d.shift = WDATA[4:0];
            default: begin
            end
         endcase
      end

      if (sample_tick) begin
         s_d.irq = 1'b1; // R4
         s_d.icap[0] = PHASE_ONE_CURRENT_INPUT; // R5
         s_d.icap[1] = PHASE_TWO_CURRENT_INPUT;
         s_d.icap[2] = PHASE_THREE_CURRENT_INPUT;
         for (int ph = 0; ph < 3; ph++) begin
            // Quarter-cycle delay gives the shifted voltage; integer samples only
            v90 = s_q.dly[ph][5'(s_q.wp - s_q.shift)];
            vprod = smul(vext(s_q.vcap[ph]), vext(s_q.vcap[ph]));
            nv[ph] = s_q.acc_v[ph] + vprod[47:0]; // R15 R17 R18
            ni[ph] = s_q.acc_i[ph] + smul(s_q.icap[ph], s_q.icap[ph]); // R16 R17
            np[ph] = s_q.acc_p[ph] + smul(vext(s_q.vcap[ph]), s_q.icap[ph]); // R16
            nq[ph] = s_q.acc_q[ph] + smul(vext(v90), s_q.icap[ph]); // R16
            s_d.dly[ph][s_q.wp] = s_q.vcap[ph];
         end
         s_d.wp = s_q.wp + 5'h01;
         now_pos = is_pos(s_q.vcap[0], s_q.sgn);
         rise = now_pos && !s_q.pos;
         s_d.pos = now_pos;
         cyc_n = s_q.cyc + {7'h00, rise};
         cnt_n = s_q.cnt + 16'h0001; // R14
         // Without mains the frame still closes at a fixed length
         close = (rise && (cyc_n >= s_q.cycles_cfg)) || (cnt_n == FRAME_MAX); // R13
         if (close) begin
            // A clear in this cycle frees the holding set, so the new frame wins
            if (!s_d.ready) begin
               s_d.hold_v = nv; // R19
               s_d.hold_i = ni;
               s_d.hold_p = np;
               s_d.hold_q = nq;
               s_d.hold_cnt = cnt_n;
               s_d.ready = 1'b1; // R12
            end else begin
               s_d.overrun = 1'b1; // R20
            end
            s_d.acc_v = '0; // R19
            s_d.acc_i = '0;
            s_d.acc_p = '0;
            s_d.acc_q = '0;
            s_d.cnt = '0;
            s_d.cyc = '0;
         end else begin
            s_d.acc_v = nv;
            s_d.acc_i = ni;
            s_d.acc_p = np;
            s_d.acc_q = nq;
            s_d.cnt = cnt_n;
            s_d.cyc = cyc_n;
         end
      end

      // Codes are relative to the 2.0 V reference; scaling is firmware's task
      if (scan_done) begin
         unique case (scan_ch) // R11
            PH1_V_CH: s_d.vcap[0] = fmt(SAR_RESULT, s_q.sgn); // R9 R10
            PH2_V_CH: s_d.vcap[1] = fmt(SAR_RESULT, s_q.sgn);
            PH3_V_CH: s_d.vcap[2] = fmt(SAR_RESULT, s_q.sgn);
            TEMP_CH: s_d.temp = fmt(SAR_RESULT, s_q.sgn);
            SYS_SUPPLY_CH: s_d.sys = fmt(SAR_RESULT, s_q.sgn);
            AUX_SUPPLY_CH: s_d.aux = fmt(SAR_RESULT, s_q.sgn);
            default: begin
            end
         endcase
      end

      if (RD) begin
         if (ADDR >= REG_HOLD_BASE) begin
            idx = 5'((ADDR - REG_HOLD_BASE) >> 2);
            if (idx[4:3] != 2'h3) begin
               unique case (idx[2:1])
                  2'h0: w64 = {{16{s_q.hold_v[idx[4:3]][47]}}, s_q.hold_v[idx[4:3]]};
                  2'h1: w64 = s_q.hold_i[idx[4:3]];
                  2'h2: w64 = s_q.hold_p[idx[4:3]];
                  2'h3: w64 = s_q.hold_q[idx[4:3]];
               endcase
            end
            s_d.rdata = idx[0] ? w64[63:32] : w64[31:0];
         end else begin
            unique case (ADDR)
               REG_CTRL: begin
                  s_d.rdata[CTRL_RUN] = s_q.run;
                  s_d.rdata[CTRL_SIGNED] = s_q.sgn;
               end
               REG_STATUS: begin
                  s_d.rdata[ST_READY] = s_q.ready;
                  s_d.rdata[ST_OVERRUN] = s_q.overrun;
               end
               REG_CYCLES: s_d.rdata = {24'h000000, s_q.cycles_cfg};
               REG_SHIFT: s_d.rdata = {27'h0000000, s_q.shift};
               REG_COUNT: s_d.rdata = {16'h0000, s_q.hold_cnt};
               REG_MON0: s_d.rdata = {s_q.sys, s_q.temp};
               REG_MON1: s_d.rdata = {16'h0000, s_q.aux};
               default: s_d.rdata = '0;
            endcase
         end
      end

      if (SRST) begin
         s_d = '0;
         s_d.run = RUN_RESET;
         s_d.sgn = SIGNED_RESET;
         s_d.cycles_cfg = CYCLES_RESET;
         s_d.shift = SHIFT_RESET;
         // Idle level of the crossing detector, else the first sample fakes a rise
         s_d.pos = is_pos(s_d.vcap[0], s_d.sgn); // R13
      end
   end

   always_ff @(posedge MCLK) begin
      s_q <= s_d;
   end

   assign RDATA = s_q.rdata;
   assign SAMPLE_IRQ = s_q.irq;
   assign FRAME_READY = s_q.ready;
endmodule : msa_acquisition
`default_nettype wire

//--- verification/msa_front_end_model.sv
`timescale 1ns/1ps
`default_nettype none
module msa_front_end_model
   import msa_pkg::*;
(
   input wire logic clk,
   input wire logic [3:0] channel,
   input wire logic convert,
   input wire logic [9:0] delta,
   output logic [9:0] result
);
   logic flip_q = 1'b1;
   logic hold_q = 1'b0;
   logic [3:0] ch_q = 4'h0;
   logic [9:0] last_q = 10'h0;
   logic [9:0] code;
   always_comb begin
      case (channel)
         PH1_V_CH: code = flip_q ? SAR_MID - delta : SAR_MID + delta;
         PH2_V_CH, PH3_V_CH: code = SAR_MID + delta;
         default: code = {channel, 6'h15};
      endcase
   end
   // Phase one swings sign each scan, so a rising crossing every second sample
   always_ff @(posedge clk) begin
      hold_q <= convert;
      if (convert) begin
         last_q <= code;
         ch_q <= channel;
      end
      if (hold_q && !convert && ch_q == CH_LAST) begin
         flip_q <= !flip_q;
      end
   end
   // Released line shows the inverse, so a late capture cannot pass
   assign result = convert ? code : (hold_q ? last_q : ~last_q);
endmodule : msa_front_end_model
`default_nettype wire

//--- verification/msa_acquisition_checker.sv
`timescale 1ns/1ps
`default_nettype none
module msa_acquisition_checker
   import msa_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic MOD_CLK,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic SAMPLE_IRQ,
   input wire logic SAR_CLK,
   input wire logic [3:0] SAR_CHANNEL,
   input wire logic SAR_SAMPLE,
   input wire logic SAR_CONVERT,
   input wire logic FRAME_READY
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SRST);
   logic [13:0] gap_q;
   logic [7:0] run_q;
   logic [4:0] conv_n_q;
   logic seen_q;
   logic [5:0] mod_run_q;
   logic mod_seen_q;
   // First gap after reset is not judged
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         mod_run_q <= 6'h0;
         mod_seen_q <= 1'b0;
         gap_q <= 14'h0;
         run_q <= 8'h0;
         conv_n_q <= 5'h0;
         seen_q <= 1'b0;
      end else begin
         mod_run_q <= $changed(MOD_CLK) ? 6'h1 : mod_run_q + 6'h1;
         mod_seen_q <= mod_seen_q | $changed(MOD_CLK);
         gap_q <= SAMPLE_IRQ ? 14'h1 : gap_q + 14'h1;
         run_q <= $changed({SAR_SAMPLE, SAR_CONVERT}) ? 8'h1 : run_q + 8'h1;
         conv_n_q <= SAMPLE_IRQ ? 5'h0 : conv_n_q + 5'($fell(SAR_CONVERT));
         seen_q <= seen_q | SAMPLE_IRQ;
      end
   end
   chk_irq_pulse: assert property (SAMPLE_IRQ |=> !SAMPLE_IRQ) else $error("sample pulse too long");
   chk_irq_spacing: assert property (SAMPLE_IRQ && seen_q |-> gap_q inside {[14'd12206:14'd12209]})
      else $error("sample period wrong");
   chk_scan_start: assert property ($rose(SAMPLE_IRQ) |-> SAR_SAMPLE && SAR_CHANNEL == 4'h0)
      else $error("scan did not start");
   chk_scan_count: assert property (SAMPLE_IRQ && seen_q |-> conv_n_q == 5'd16)
      else $error("scan channel count wrong");
   chk_sample_len: assert property ($fell(SAR_SAMPLE) |-> SAR_CONVERT && run_q inside {[8'd85:8'd105]})
      else $error("sampling length wrong");
   chk_convert_len: assert property ($fell(SAR_CONVERT) |-> run_q inside {[8'd149:8'd151]})
      else $error("convert length wrong");
   chk_phase_split: assert property (!(SAR_SAMPLE && SAR_CONVERT)) else $error("sample and convert overlap");
   chk_channel_step: assert property ($changed(SAR_CHANNEL) |->
      SAR_CHANNEL == 4'($past(SAR_CHANNEL) + 4'h1) || SAR_CHANNEL == 4'h0) else $error("channel skipped");
   chk_sar_clk_rate: assert property ($rose(SAR_CLK) |-> SAR_CLK[*6] ##[1:2] !SAR_CLK)
      else $error("converter clock rate wrong");
   chk_mod_clk_rate: assert property ($changed(MOD_CLK) && mod_seen_q |-> mod_run_q inside {[6'd23:6'd24]})
      else $error("modulator clock rate wrong");
   chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("read data outside slot");
   chk_ready_clear: assert property ($fell(FRAME_READY) |->
      $past(WR) && $past(ADDR) == REG_STATUS && $past(WDATA[0])) else $error("ready dropped unasked");
   cov_irq: cover property (SAMPLE_IRQ);
   cov_frame: cover property ($rose(FRAME_READY));
   cov_scan_end: cover property ($fell(SAR_CONVERT) && SAR_CHANNEL == CH_LAST);
endmodule : msa_acquisition_checker
bind msa_acquisition msa_acquisition_checker chk_u (.MCLK(MCLK), .SRST(SRST), .MOD_CLK(MOD_CLK), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SAMPLE_IRQ(SAMPLE_IRQ), .SAR_CLK(SAR_CLK),
   .SAR_CHANNEL(SAR_CHANNEL),
   .SAR_SAMPLE(SAR_SAMPLE), .SAR_CONVERT(SAR_CONVERT), .FRAME_READY(FRAME_READY));
`default_nettype wire

//--- verification/msa_acquisition_tb.sv
`timescale 1ns/1ps
`default_nettype none
module msa_acquisition_tb
   import msa_pkg::*;
;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] addr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [23:0] cur1 = 24'h0;
   logic [23:0] cur2 = 24'h0;
   logic [23:0] cur3 = 24'h0;
   logic [9:0] delta = 10'h1;
   logic [31:0] rdata;
   logic mod_clk, irq, sar_clk, sar_sample, sar_convert, ready;
   logic [3:0] sar_ch;
   logic [9:0] sar_res;
   int bad_count = 0;
   int tests_run = 0;
   integer seed = 32'hc778530e;
   always #10 mclk = ~mclk;
   msa_acquisition dut_u (.MCLK(mclk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .PHASE_ONE_CURRENT_INPUT(cur1), .PHASE_TWO_CURRENT_INPUT(cur2),
      .PHASE_THREE_CURRENT_INPUT(cur3), .MOD_CLK(mod_clk), .SAMPLE_IRQ(irq), .SAR_CLK(sar_clk),
      .SAR_CHANNEL(sar_ch), .SAR_SAMPLE(sar_sample), .SAR_CONVERT(sar_convert), .SAR_RESULT(sar_res),
      .FRAME_READY(ready));
   msa_front_end_model fe_u (.clk(mclk), .channel(sar_ch), .convert(sar_convert), .delta(delta), .result(sar_res));
   function automatic logic [15:0] sval(input logic [9:0] c);
      return {c ^ 10'h200, 6'h0};
   endfunction : sval
   function automatic logic [9:0] chcode(input logic [3:0] ch);
      return {ch, 6'h15};
   endfunction : chcode
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      reg_rd(a, d);
      check({32'h0, d}, {32'h0, exp});
   endtask : rchk
   task automatic rd64(input logic [7:0] a, output logic [63:0] v);
      reg_rd(a, v[31:0]);
      reg_rd(a + 8'h4, v[63:32]);
   endtask : rd64
   // Bounded wait for the sample pulse (0) or frame ready (1)
   task automatic wait_for(input logic sel, input int bound);
      for (int n = 0; n <= bound; n++) begin
         @(posedge mclk);
         #1;
         if ((sel ? ready : irq) === 1'b1) begin
            return;
         end
      end
      $display("ERROR %0t wait timed out", $time);
      bad_count++;
      end_sim();
   endtask : wait_for
   initial begin
      logic [63:0] got;
      logic [31:0] d32;
      longint i1, i2, dl, vsq;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      i1 = longint'($signed(24'($random(seed))));
      i2 = longint'($signed(24'($random(seed))));
      dl = 1 + {$random(seed)} % 300;
      vsq = 2 * dl * dl * 4096;
      cur1 <= 24'(i1);
      cur2 <= 24'(i2);
      cur3 <= 24'($random(seed));
      delta <= 10'(dl);
      rchk(REG_CTRL, 32'h3);
      rchk(REG_STATUS, 32'h0);
      rchk(REG_CYCLES, 32'h32);
      rchk(REG_SHIFT, 32'h14);
      rchk(8'he0, 32'h0);
      reg_wr(8'h7c, 32'hffffffff);
      rchk(8'h7c, 32'h0);
      reg_wr(REG_CYCLES, 32'h1);
      rchk(REG_CYCLES, 32'h1);
      // Delay of three samples reaches the first negative swing in the second frame
      reg_wr(REG_SHIFT, 32'h3);
      rchk(REG_SHIFT, 32'h3);
      wait_for(1'b0, 13000);
      repeat (4200) @(posedge mclk);
      rchk(REG_MON0, {sval(chcode(4'hb)), sval(chcode(4'ha))});
      reg_rd(REG_MON1, d32);
      check({48'h0, d32[15:0]}, {48'h0, sval(chcode(4'hc))});
      wait_for(1'b1, 40000);
      reg_wr(REG_STATUS, 32'h1);
      check({63'h0, ready}, 64'h0);
      wait_for(1'b1, 40000);
      rchk(REG_COUNT, 32'h2);
      rd64(REG_HOLD_BASE, got);
      check(got, vsq);
      rd64(8'h88, got);
      check(got, 2 * i1 * i1);
      rd64(8'h90, got);
      check(got, 64'h0);
      rd64(8'hb0, got);
      check(got, 2 * 64 * longint'(delta) * i2);
      rd64(8'h98, got);
      check(got, -64 * dl * i1);
      wait_for(1'b0, 13000);
      wait_for(1'b0, 13000);
      repeat (4) @(posedge mclk);
      rchk(REG_STATUS, 32'h3);
      rd64(REG_HOLD_BASE, got);
      check(got, vsq);
      reg_wr(REG_CTRL, 32'h1);
      repeat (4200) @(posedge mclk);
      reg_rd(REG_MON1, d32);
      check({48'h0, d32[15:0]}, {54'h0, chcode(4'hc)});
      reg_wr(REG_STATUS, 32'h3);
      rchk(REG_STATUS, 32'h0);
      end_sim();
   end
endmodule : msa_acquisition_tb
`default_nettype wire
